/* bench/bss_sequencer_chk.sv */
// Port-level assertions for the start-up sequencer
module bss_sequencer_chk #(
  parameter int TRI_W = 8
) (
  input wire logic             I_CLK,
  input wire logic             I_RST,
  input wire logic             I_BIAS_OK,
  input wire logic             I_EN_ABOVE,
  input wire logic             I_SETPT_REACHED,
  input wire logic             I_OC_TRIP,
  input wire logic             I_RAMP_ABOVE_OUT,
  input wire logic [TRI_W-1:0] I_EA_LEVEL,
  input wire logic             O_HIGH_SIDE_GATE,
  input wire logic             O_LOW_SIDE_GATE,
  input wire logic             O_SETPOINT_CURRENT,
  input wire logic             O_EA_ENABLE,
  input wire logic             O_OSC_RUN,
  input wire logic [6:0]       O_REF_CODE,
  input wire logic [7:0]       O_SETPOINT_CODE,
  input wire logic             O_SS_DONE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_no_overlap; !(O_HIGH_SIDE_GATE && O_LOW_SIDE_GATE); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
  property p_gate_off; O_SETPOINT_CURRENT |-> !O_LOW_SIDE_GATE && !O_HIGH_SIDE_GATE; endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate on while sampling");
  property p_done_full; O_SS_DONE |-> O_REF_CODE == 7'h40; endproperty
  a_done_full: assert property (p_done_full) else $error("done below full");
  // Three cycles is the bench's init interval
  property p_init_gap; $fell(O_SETPOINT_CURRENT) && O_OSC_RUN |-> !O_EA_ENABLE [*3]; endproperty
  a_init_gap: assert property (p_init_gap) else $error("amp on too early");
  property p_ref_step;
    O_REF_CODE != $past(O_REF_CODE) |-> O_REF_CODE == $past(O_REF_CODE) + 7'h01 || O_REF_CODE == 7'h00;
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("ref jumped");
  property p_ref_hold;
    O_REF_CODE != $past(O_REF_CODE) && O_REF_CODE != 7'h00
      |=> (O_REF_CODE == $past(O_REF_CODE) || O_REF_CODE == 7'h00) [*3];
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("ref step short");
  property p_disable; !I_EN_ABOVE [*8] |-> !O_OSC_RUN && !O_HIGH_SIDE_GATE && !O_LOW_SIDE_GATE; endproperty
  a_disable: assert property (p_disable) else $error("still running");
  property p_bias_clear; !I_BIAS_OK [*8] |-> O_SETPOINT_CODE == 8'h00 && !O_OSC_RUN; endproperty
  a_bias_clear: assert property (p_bias_clear) else $error("set point kept");
  property p_hold_code;
    O_OSC_RUN && !O_SETPOINT_CURRENT && !$past(O_SETPOINT_CURRENT) |-> $stable(O_SETPOINT_CODE);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("set point moved");
  property p_gate_amp; O_HIGH_SIDE_GATE || O_LOW_SIDE_GATE |-> O_EA_ENABLE && O_OSC_RUN; endproperty
  a_gate_amp: assert property (p_gate_amp) else $error("gate before ramp");

  c_done: cover property ($rose(O_SS_DONE));
  c_retry: cover property ($fell(O_EA_ENABLE) && O_OSC_RUN);
  c_sample: cover property ($fell(O_SETPOINT_CURRENT));
endmodule // bss_sequencer_chk

bind bss_sequencer bss_sequencer_chk #(.TRI_W(TRI_W)) i_bss_sequencer_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_BIAS_OK(I_BIAS_OK), .I_EN_ABOVE(I_EN_ABOVE),
  .I_SETPT_REACHED(I_SETPT_REACHED), .I_OC_TRIP(I_OC_TRIP),
  .I_RAMP_ABOVE_OUT(I_RAMP_ABOVE_OUT), .I_EA_LEVEL(I_EA_LEVEL),
  .O_HIGH_SIDE_GATE(O_HIGH_SIDE_GATE), .O_LOW_SIDE_GATE(O_LOW_SIDE_GATE),
  .O_SETPOINT_CURRENT(O_SETPOINT_CURRENT), .O_EA_ENABLE(O_EA_ENABLE),
  .O_OSC_RUN(O_OSC_RUN), .O_REF_CODE(O_REF_CODE), .O_SETPOINT_CODE(O_SETPOINT_CODE),
  .O_SS_DONE(O_SS_DONE));

/* bench/bss_sequencer_tb_top.sv */
// Self-checking bench for the buck start-up sequencer
module bss_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  localparam int STP = 4;
  logic       clk, rst, bias, oc, pull_dn, en_above, setpt_rch, ramp_above;
  logic       hs, ls, sp_cur, ea_en, osc, done;
  logic [7:0] target, code;
  logic [6:0] prebias, ref_code;
  logic [3:0] st;
  int         mismatches, checks;

  // Index 0 oscillator, 1 set-point current, 2 amplifier, 3 done
  assign st = {done, ea_en, sp_cur, osc};

  bss_sequencer #(.DELAY_CYC(DLY), .SAMPLE_STEP_CYC(2), .SS_STEP_CYC(STP), .INIT_CYC(3))
  i_bss_sequencer (
    .I_CLK(clk), .I_RST(rst), .I_BIAS_OK(bias), .I_EN_ABOVE(en_above),
    .I_SETPT_REACHED(setpt_rch), .I_OC_TRIP(oc), .I_RAMP_ABOVE_OUT(ramp_above),
    .I_EA_LEVEL(8'h80), .O_HIGH_SIDE_GATE(hs), .O_LOW_SIDE_GATE(ls),
    .O_SETPOINT_CURRENT(sp_cur), .O_EA_ENABLE(ea_en), .O_OSC_RUN(osc),
    .O_REF_CODE(ref_code), .O_SETPOINT_CODE(code), .O_SS_DONE(done));
  bss_stage_model i_bss_stage_model (
    .i_clk(clk), .i_pull_down(pull_dn), .i_target(target), .i_prebias(prebias),
    .i_setpoint_code(code), .i_ref_code(ref_code), .o_en_above(en_above),
    .o_setpt_reached(setpt_rch), .o_ramp_above_out(ramp_above));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_on(input int idx, input logic v, input int lim, output int n);
    n = 0;
    while (st[idx] !== v && n < lim) begin
      step(1);
      n++;
    end
    check(st[idx], v);
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_startup;
    int n;
    bias = 1;
    step(40);
    check(osc, 1'b0);
    pull_dn = 0;
    wait_on(1, 1'b1, 60, n);
    n = 0;
    while (code === 8'h00 && n < 100) begin
      step(1);
      n++;
    end
    check(n >= DLY, 1'b1);
    wait_on(1, 1'b0, 600, n);
    check(code >= 8'h10 && code <= 8'h14, 1'b1);
    wait_on(2, 1'b1, 20, n);
    check(n >= 3, 1'b1);
    wait_on(3, 1'b1, 400, n);
    check(n >= 65 * STP - 6 && n <= 65 * STP + 6, 1'b1);
    check(ref_code, 7'h40);
    $display("test startup done");
  endtask

  task automatic t_resample;
    int n;
    pull_dn = 1;
    wait_on(0, 1'b0, 10, n);
    check(hs | ls, 1'b0);
    target = 8'h80;
    pull_dn = 0;
    wait_on(1, 1'b1, 60, n);
    wait_on(1, 1'b0, 600, n);
    check(n >= DLY + 256, 1'b1);
    check(code >= 8'h80 && code <= 8'h84, 1'b1);
    wait_on(3, 1'b1, 400, n);
    $display("test resample done");
  endtask

  task automatic t_retry;
    int n;
    logic [7:0] held;
    held = code;
    oc = 1;
    wait_on(3, 1'b0, 10, n);
    check(hs | ls, 1'b0);
    wait_on(2, 1'b0, 10, n);
    wait_on(2, 1'b1, 700, n);
    check(n >= 2 * 65 * STP, 1'b1);
    wait_on(2, 1'b0, 20, n);
    oc = 0;
    wait_on(2, 1'b1, 700, n);
    wait_on(3, 1'b1, 400, n);
    check(code, held);
    $display("test retry done");
  endtask

  task automatic t_prebias;
    int n, bad;
    for (int i = 0; i < 2; i++) begin
      pull_dn = 1;
      step(10);
      prebias = i ? 7'h7f : 7'h28;
      pull_dn = 0;
      wait_on(2, 1'b1, 700, n);
      bad = 0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
        if ((hs | ls) && ref_code <= prebias) bad++;
        step(1);
        n++;
      end
      check(bad, 0);
      n = 0;
      while ((hs | ls) !== 1'b1 && n < 600) begin
        step(1);
        n++;
      end
      check(hs | ls, 1'b1);
    end
    $display("test prebias done");
  endtask

  task automatic t_bias;
    int n;
    bias = 0;
    step(10);
    check(code, 8'h00);
    bias = 1;
    wait_on(1, 1'b1, 60, n);
    $display("test bias done");
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // About 3500 cycles are expected; the limit leaves ample margin
  initial begin
    #160us;
    mismatches++;
    finish_test();
  end

  initial begin
    rst = 1;
    bias = 0;
    oc = 0;
    pull_dn = 1;
    target = 8'h10;
    prebias = 7'h00;
    repeat (20) @(posedge clk);
    #1;
    rst = 0;
    t_startup();
    t_resample();
    t_retry();
    t_prebias();
    t_bias();
    finish_test();
  end
endmodule // bss_sequencer_tb_top

/* bench/bss_stage_model.sv */
// Power stage and enable pull-down, seen through their comparator outputs
module bss_stage_model (
  input  wire logic       i_clk,
  input  wire logic       i_pull_down,
  input  wire logic [7:0] i_target,
  input  wire logic [6:0] i_prebias,
  input  wire logic [7:0] i_setpoint_code,
  input  wire logic [6:0] i_ref_code,
  output logic            o_en_above,
  output logic            o_setpt_reached,
  output logic            o_ramp_above_out
);
  logic [3:0] charge_r;

  // A released pin charges slowly, so the trip level is crossed some cycles later
  always_ff @(posedge i_clk) begin
    if (i_pull_down) begin
      charge_r <= 4'h0;
    end else if (charge_r != 4'hf) begin
      charge_r <= charge_r + 4'h1;
    end
  end

  assign o_en_above       = (charge_r == 4'hf);
  assign o_setpt_reached  = (i_setpoint_code >= i_target);
  assign o_ramp_above_out = (i_ref_code > i_prebias);
endmodule // bss_stage_model

/* common/bss_params.svh */
// Timing and encoding constants for the buck start-up sequencer
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

`define BSS_CLK_PERIOD_NS   8
`define BSS_DELAY_NS        6800000
`define BSS_SAMPLE_MAX_NS   3400000
`define BSS_SOFTSTART_NS    13600000
`define BSS_INIT_NS         10000
`define BSS_SS_STEPS        64
`define BSS_DAC_STEPS       256
`define BSS_DUMMY_RUNS      2
`define BSS_DELAY_CYC       ((`BSS_DELAY_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)
`define BSS_SAMPLE_STEP_CYC (`BSS_SAMPLE_MAX_NS / (`BSS_CLK_PERIOD_NS * `BSS_DAC_STEPS))
`define BSS_SS_STEP_CYC     ((`BSS_SOFTSTART_NS + `BSS_CLK_PERIOD_NS * `BSS_SS_STEPS - 1) \
                             / (`BSS_CLK_PERIOD_NS * `BSS_SS_STEPS))
`define BSS_INIT_CYC        ((`BSS_INIT_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)
`define BSS_REF_RST         7'h00
`define BSS_REF_FULL        7'h40
`define BSS_SETPT_RST       8'h00
`define BSS_SETPT_MAX       8'hff

`endif

/* common/bss_pkg.sv */
// Types shared by the buck start-up sequencer
package bss_pkg;

  typedef enum logic [6:0] {
    ST_OFF    = 7'h01,
    ST_DELAY  = 7'h02,
    ST_SAMPLE = 7'h04,
    ST_INIT   = 7'h08,
    ST_SOFT   = 7'h10,
    ST_RUN    = 7'h20,
    ST_DUMMY  = 7'h40
  } bss_state_t;

  // Comparator levels after synchronisation
  typedef struct packed {
    logic bias_ok;
    logic en_above;
    logic setpt_reached;
    logic oc_trip;
    logic ramp_above_out;
  } bss_cmp_t;

endpackage

/* src/bss_sequencer.sv */
// Start-up sequencer: POR/enable gating, set-point sample, soft-start, hiccup retry
`include "bss_params.svh"

module bss_sequencer #(
  parameter int unsigned DELAY_CYC       = `BSS_DELAY_CYC,
  parameter int unsigned SAMPLE_STEP_CYC = `BSS_SAMPLE_STEP_CYC,
  parameter int unsigned SS_STEP_CYC     = `BSS_SS_STEP_CYC,
  parameter int unsigned INIT_CYC        = `BSS_INIT_CYC,
  parameter int          TMR_W           = 20,
  parameter int          TRI_W           = 8
) (
  input  wire logic             I_CLK,
  input  wire logic             I_RST,
  input  wire logic             I_BIAS_OK,
  input  wire logic             I_EN_ABOVE,
  input  wire logic             I_SETPT_REACHED,
  input  wire logic             I_OC_TRIP,
  input  wire logic             I_RAMP_ABOVE_OUT,
  input  wire logic [TRI_W-1:0] I_EA_LEVEL,
  output logic                  O_HIGH_SIDE_GATE,
  output logic                  O_LOW_SIDE_GATE,
  output logic                  O_SETPOINT_CURRENT,
  output logic                  O_EA_ENABLE,
  output logic                  O_OSC_RUN,
  output logic [6:0]            O_REF_CODE,
  output logic [7:0]            O_SETPOINT_CODE,
  output logic                  O_SS_DONE
);

  localparam logic [TMR_W-1:0] DELAY_TC  = TMR_W'(DELAY_CYC - 1);
  localparam logic [TMR_W-1:0] SAMPLE_TC = TMR_W'(SAMPLE_STEP_CYC - 1);
  localparam logic [TMR_W-1:0] SS_TC     = TMR_W'(SS_STEP_CYC - 1);
  localparam logic [TMR_W-1:0] INIT_TC   = TMR_W'(INIT_CYC - 1);

  bss_pkg::bss_cmp_t   raw;
  bss_pkg::bss_cmp_t   cmp;
  bss_pkg::bss_state_t state_r;
  bss_pkg::bss_state_t state_nxt;

  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_tc;
  logic             tmr_hit;
  logic [6:0]       ref_r;
  logic [7:0]       setpt_r;
  logic             setpt_valid_r;
  logic             dummy_cnt_r;
  logic             gates_ok_r;
  logic             ea_en_r;
  logic             done_r;
  logic [TRI_W-1:0] tri_r;
  logic             tri_up_r;
  logic             pwm;
  logic             drive;
  logic             step_tick;
  logic             ramp_end;

  // Comparator outputs are asynchronous to the internal clock
  assign raw.bias_ok        = I_BIAS_OK;
  assign raw.en_above       = I_EN_ABOVE;
  assign raw.setpt_reached  = I_SETPT_REACHED;
  assign raw.oc_trip        = I_OC_TRIP;
  assign raw.ramp_above_out = I_RAMP_ABOVE_OUT;

  bss_sync3 #(
    .W ($bits(bss_pkg::bss_cmp_t))
  ) u_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (raw),
    .o_q   (cmp)
  );

  // One shared timer; its terminal count depends on the phase
  always_comb begin
    case (state_r)
      bss_pkg::ST_DELAY:  tmr_tc = DELAY_TC;
      bss_pkg::ST_SAMPLE: tmr_tc = SAMPLE_TC;
      bss_pkg::ST_INIT:   tmr_tc = INIT_TC;
      default:            tmr_tc = SS_TC;
    endcase
  end

  assign tmr_hit   = (tmr_r == tmr_tc);
  assign step_tick = tmr_hit && (state_r == bss_pkg::ST_SOFT || state_r == bss_pkg::ST_DUMMY);
  assign ramp_end  = step_tick && (ref_r == `BSS_REF_FULL);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bss_pkg::ST_OFF: begin
        // Held low enable keeps the block here even with bias present
        if (cmp.bias_ok && cmp.en_above) begin
          state_nxt = bss_pkg::ST_DELAY;
        end
      end
      bss_pkg::ST_DELAY: begin
        if (tmr_hit) begin
          state_nxt = bss_pkg::ST_SAMPLE;
        end
      end
      bss_pkg::ST_SAMPLE: begin
        // Comparator already set on entry gives a zero-length sample
        if (cmp.setpt_reached || (tmr_hit && setpt_r == `BSS_SETPT_MAX)) begin
          state_nxt = bss_pkg::ST_INIT;
        end
      end
      bss_pkg::ST_INIT: begin
        if (tmr_hit) begin
          state_nxt = bss_pkg::ST_SOFT;
        end
      end
      bss_pkg::ST_SOFT: begin
        // No input-supply check beyond bias: only an overcurrent, bias loss or a low enable ends the ramp early
        if (cmp.oc_trip) begin
          state_nxt = bss_pkg::ST_DUMMY;
        end else if (ramp_end) begin
          state_nxt = bss_pkg::ST_RUN;
        end
      end
      bss_pkg::ST_RUN: begin
        if (cmp.oc_trip) begin
          state_nxt = bss_pkg::ST_DUMMY;
        end
      end
      bss_pkg::ST_DUMMY: begin
        // Retry skips delay and sampling, keeping the held set point
        if (ramp_end && dummy_cnt_r) begin
          state_nxt = bss_pkg::ST_SOFT;
        end
      end
      default: begin
        state_nxt = bss_pkg::ST_OFF;
      end
    endcase
    // Loss of bias or a pulled-down enable overrides every phase
    if (!cmp.bias_ok || !cmp.en_above) begin
      state_nxt = bss_pkg::ST_OFF;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_r <= bss_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Timer restarts on every phase change and at each terminal count
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r || tmr_hit || state_r == bss_pkg::ST_OFF
                 || state_r == bss_pkg::ST_RUN) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // Set-point counter: counts up until the pin comparator trips or the count reaches 0xff
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      setpt_r       <= `BSS_SETPT_RST;
      setpt_valid_r <= 1'b0;
    end else if (!cmp.bias_ok) begin
      setpt_r       <= `BSS_SETPT_RST;
      setpt_valid_r <= 1'b0;
    end else if (state_r == bss_pkg::ST_DELAY) begin
      setpt_r       <= `BSS_SETPT_RST;
      setpt_valid_r <= 1'b0;
    end else if (state_r == bss_pkg::ST_SAMPLE) begin
      if (cmp.setpt_reached || setpt_r == `BSS_SETPT_MAX) begin
        setpt_valid_r <= 1'b1;
      end else if (tmr_hit) begin
        setpt_r <= setpt_r + 8'h01;
      end
    end
  end

  // Reference ramp; dummy runs count steps but keep the reference at zero
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ref_r <= `BSS_REF_RST;
    end else if (state_nxt != state_r) begin
      ref_r <= `BSS_REF_RST;
    end else if (ramp_end && state_r == bss_pkg::ST_DUMMY) begin
      // Restart the count so the second dummy run is a full-length one
      ref_r <= `BSS_REF_RST;
    end else if (step_tick && ref_r != `BSS_REF_FULL) begin
      ref_r <= ref_r + 7'h01;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      dummy_cnt_r <= 1'b0;
    end else if (state_r != bss_pkg::ST_DUMMY) begin
      dummy_cnt_r <= 1'b0;
    end else if (ramp_end) begin
      dummy_cnt_r <= ~dummy_cnt_r;
    end
  end

  // Gate release latch for pre-biased outputs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gates_ok_r <= 1'b0;
    end else if (state_r != bss_pkg::ST_SOFT && state_r != bss_pkg::ST_RUN) begin
      gates_ok_r <= 1'b0;
    end else if (state_r == bss_pkg::ST_SOFT && cmp.ramp_above_out) begin
      gates_ok_r <= 1'b1;
    end else if (state_r == bss_pkg::ST_RUN) begin
      gates_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ea_en_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      ea_en_r <= (state_r == bss_pkg::ST_SOFT || state_r == bss_pkg::ST_RUN);
      done_r  <= (state_r == bss_pkg::ST_RUN);
    end
  end

  // Triangle oscillator, halted while the block is disabled
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tri_r    <= '0;
      tri_up_r <= 1'b1;
    end else if (state_r == bss_pkg::ST_OFF) begin
      tri_r    <= '0;
      tri_up_r <= 1'b1;
    end else if (tri_up_r) begin
      tri_r <= tri_r + TRI_W'(1);
      if (tri_r == {{(TRI_W-1){1'b1}}, 1'b0}) begin
        tri_up_r <= 1'b0;
      end
    end else begin
      tri_r <= tri_r - TRI_W'(1);
      if (tri_r == TRI_W'(1)) begin
        tri_up_r <= 1'b1;
      end
    end
  end

  assign pwm   = (I_EA_LEVEL > tri_r);
  assign drive = ea_en_r && gates_ok_r && cmp.bias_ok && cmp.en_above;

  // Gate outputs registered; an overcurrent drops them on the next edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_HIGH_SIDE_GATE <= 1'b0;
      O_LOW_SIDE_GATE  <= 1'b0;
    end else if (!drive || cmp.oc_trip || state_r == bss_pkg::ST_OFF) begin
      O_HIGH_SIDE_GATE <= 1'b0;
      O_LOW_SIDE_GATE  <= 1'b0;
    end else begin
      O_HIGH_SIDE_GATE <= pwm;
      O_LOW_SIDE_GATE  <= ~pwm;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_SETPOINT_CURRENT <= 1'b0;
      O_OSC_RUN          <= 1'b0;
      O_REF_CODE         <= `BSS_REF_RST;
      O_SETPOINT_CODE    <= `BSS_SETPT_RST;
    end else begin
      O_SETPOINT_CURRENT <= (state_r == bss_pkg::ST_DELAY || state_r == bss_pkg::ST_SAMPLE);
      O_OSC_RUN          <= (state_r != bss_pkg::ST_OFF);
      O_REF_CODE         <= (state_r == bss_pkg::ST_SOFT || state_r == bss_pkg::ST_RUN)
                            ? ((state_r == bss_pkg::ST_RUN) ? `BSS_REF_FULL : ref_r)
                            : `BSS_REF_RST;
      O_SETPOINT_CODE    <= setpt_r;
    end
  end

  assign O_EA_ENABLE = ea_en_r;
  assign O_SS_DONE   = done_r;

  // setpt_valid_r is kept for a future set-point ready indicator
  logic unused_ok;
  assign unused_ok = setpt_valid_r;

endmodule // bss_sequencer

/* src/bss_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
module bss_sync3 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-bit agreement filter; s1 feeds only s2
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_q[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // bss_sync3
